//--- hw/acqs_pkg.sv
// Purpose: shared constants and types for the conversion sequencer
// Assumes: 25 MHz core clock, 32-bit AXI4-Lite register bus
// Notes: register offsets are byte addresses, one 32-bit word each
package acqs_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [4:0] OFS_CONTROL = 5'h00;
  localparam logic [4:0] OFS_CONFIG = 5'h04;
  localparam logic [4:0] OFS_RES_HIGH = 5'h08;
  localparam logic [4:0] OFS_RES_LOW = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_PIN_CFG = 5'h14;
  localparam logic [4:0] OFS_PORT = 5'h18;
  localparam logic [4:0] OFS_CMP_MODE = 5'h1C;

  // control register fields
  localparam int unsigned CTRL_ON_BIT = 0;
  localparam int unsigned CTRL_START_BIT = 1;
  localparam int unsigned CTRL_CHAN_LSB = 2;
  localparam int unsigned CHAN_W = 4;

  // configuration register fields
  localparam int unsigned CFG_CLK_LSB = 0;
  localparam int unsigned CFG_ACQ_LSB = 3;
  localparam int unsigned CFG_CAL_BIT = 6;
  localparam int unsigned SEL_W = 3;

  localparam int unsigned STAT_DONE_BIT = 0;
  localparam int unsigned PIN_W = 8;
  localparam int unsigned MODE_W = 4;
  localparam logic [3:0] MODE_SPECIAL_TRIG = 4'hB;

  // conversion clock select codes
  localparam logic [2:0] CLKSEL_DIV2 = 3'h0;
  localparam logic [2:0] CLKSEL_DIV4 = 3'h4;
  localparam logic [2:0] CLKSEL_DIV8 = 3'h1;
  localparam logic [2:0] CLKSEL_DIV16 = 3'h5;
  localparam logic [2:0] CLKSEL_DIV32 = 3'h2;
  localparam logic [2:0] CLKSEL_DIV64 = 3'h6;
  localparam logic [2:0] CLKSEL_RC = 3'h3;
  localparam logic [6:0] DIV_2 = 7'h02;
  localparam logic [6:0] DIV_4 = 7'h04;
  localparam logic [6:0] DIV_8 = 7'h08;
  localparam logic [6:0] DIV_16 = 7'h10;
  localparam logic [6:0] DIV_32 = 7'h20;
  localparam logic [6:0] DIV_64 = 7'h40;

  // acquisition time codes and lengths in conversion-bit periods
  localparam logic [2:0] ACQ_CODE_NONE = 3'h0;
  localparam logic [2:0] ACQ_CODE_FOUR = 3'h2;
  localparam logic [4:0] ACQ_TADS_FOUR = 5'h04;

  // sequencing counts
  localparam int unsigned RES_W = 10;
  localparam logic [3:0] CONV_TADS = 4'hB;
  localparam logic [3:0] HOLD_TADS = 4'h2;
  localparam logic [2:0] INSTR_CYCLES = 3'h4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_SAMPLE,
    ST_DELAY,
    ST_ACQ,
    ST_CONV,
    ST_HOLD
  } acqs_state_type;
endpackage : acqs_pkg

//--- hw/acqs_sequencer.sv
// Purpose: acquisition and conversion sequencer for a 10-bit SAR converter
// Assumes: cmp_i and trig_i are registered on core_clk_i by their sources
// Notes: AXI4-Lite register slave, one write and one read outstanding
`timescale 1ns/1ps
module acqs_sequencer
  import acqs_pkg::*;
#(
  parameter logic [4:0] ACQ_TADS_CODE1 = 5'h02,
  parameter logic [4:0] ACQ_TADS_CODE3 = 5'h06,
  parameter logic [4:0] ACQ_TADS_CODE4 = 5'h08,
  parameter logic [4:0] ACQ_TADS_CODE5 = 5'h0C,
  parameter logic [4:0] ACQ_TADS_CODE6 = 5'h10,
  parameter logic [4:0] ACQ_TADS_CODE7 = 5'h14
)
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // axi4-lite write
  input wire logic [acqs_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [acqs_pkg::DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [acqs_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [acqs_pkg::DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // analog front end
  input wire logic cmp_i,
  input wire logic rc_clk_i,
  output logic sample_o,
  output logic [acqs_pkg::CHAN_W-1:0] channel_sel_o,
  output logic [acqs_pkg::RES_W-1:0] trial_code_o,
  output logic cal_mode_o,
  // port pins and compare unit
  input wire logic [acqs_pkg::PIN_W-1:0] port_pin_i,
  input wire logic trig_i,
  output logic timer_clr_o
);
  import acqs_pkg::*;

  acqs_state_type state_reg;
  logic aw_rdy_reg;
  logic w_rdy_reg;
  logic bvalid_reg;
  logic ar_rdy_reg;
  logic rvalid_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic converter_on_reg;
  logic start_reg;
  logic [CHAN_W-1:0] chan_reg;
  logic [SEL_W-1:0] conv_clk_sel_reg;
  logic [SEL_W-1:0] acq_time_sel_reg;
  logic calib_request_reg;
  logic cal_pending_reg;
  logic cal_run_reg;
  logic conv_done_flag_reg;
  logic [PIN_W-1:0] analog_pin_cfg_a_reg;
  logic [MODE_W-1:0] compare_mode_sel_reg;
  logic [RES_W-1:0] result_reg;
  logic [RES_W-1:0] offset_reg;
  logic [RES_W-1:0] code_reg;
  logic [4:0] tad_cnt_reg;
  logic [4:0] acq_len_reg;
  logic [2:0] dly_cnt_reg;
  logic tad_clr_reg;
  logic [PIN_W-1:0] pin_s1_reg;
  logic [PIN_W-1:0] pin_s2_reg;
  logic [PIN_W-1:0] pin_s3_reg;
  logic [PIN_W-1:0] pin_lvl_reg;
  logic tad_tick;
  logic tad_tick_raw;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_cfg;
  logic trig_hit;
  logic conv_busy;
  logic conv_finish;
  logic conv_abort;
  logic [4:0] acq_len;
  logic [3:0] bit_idx;
  logic [RES_W-1:0] code_next;
  logic [RES_W-1:0] corrected;

  acqs_tad_gen u_tad_gen (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .clr_i(tad_clr_reg),
    .sel_i(conv_clk_sel_reg),
    .rc_clk_i(rc_clk_i),
    .tick_o(tad_tick_raw)
  );

  // the clear lands one clock late; a tick from the old count would cut the first period
  assign tad_tick = tad_tick_raw && !tad_clr_reg;

  // register bus handshakes
  assign wr_fire = !aw_rdy_reg && !w_rdy_reg && !bvalid_reg;
  assign wr_ctrl = wr_fire && wstrb_reg[0] && (waddr_reg == OFS_CONTROL);
  assign wr_cfg = wr_fire && wstrb_reg[0] && (waddr_reg == OFS_CONFIG);

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      aw_rdy_reg <= 1'b1;
      w_rdy_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid_i && aw_rdy_reg)
      begin
        aw_rdy_reg <= 1'b0;
        waddr_reg <= {s_axi_awaddr_i[ADDR_W-1:2], 2'h0};
      end
      if (s_axi_wvalid_i && w_rdy_reg)
      begin
        w_rdy_reg <= 1'b0;
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
      end
      if (wr_fire)
        bvalid_reg <= 1'b1;
      else if (bvalid_reg && s_axi_bready_i)
      begin
        bvalid_reg <= 1'b0;
        aw_rdy_reg <= 1'b1;
        w_rdy_reg <= 1'b1;
      end
    end
  end

  // every word offset up to the top of the window is mapped
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      ar_rdy_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end
    else if (s_axi_arvalid_i && ar_rdy_reg)
    begin
      ar_rdy_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
      unique case ({s_axi_araddr_i[ADDR_W-1:2], 2'h0})
        OFS_CONTROL: rdata_reg[7:0] <= {2'h0, chan_reg, start_reg, converter_on_reg};
        OFS_CONFIG: rdata_reg[7:0] <= {1'b0, calib_request_reg, acq_time_sel_reg,
                                       conv_clk_sel_reg};
        OFS_RES_HIGH: rdata_reg[1:0] <= result_reg[RES_W-1:8];
        OFS_RES_LOW: rdata_reg[7:0] <= result_reg[7:0];
        OFS_STATUS: rdata_reg[STAT_DONE_BIT] <= conv_done_flag_reg;
        OFS_PIN_CFG: rdata_reg[PIN_W-1:0] <= analog_pin_cfg_a_reg;
        OFS_PORT: rdata_reg[PIN_W-1:0] <= pin_lvl_reg & analog_pin_cfg_a_reg;
        OFS_CMP_MODE: rdata_reg[MODE_W-1:0] <= compare_mode_sel_reg;
        default: rresp_reg <= RESP_SLVERR;
      endcase
    end
    else if (rvalid_reg && s_axi_rready_i)
    begin
      rvalid_reg <= 1'b0;
      ar_rdy_reg <= 1'b1;
    end
  end

  // port pins: a change counts once the second and third stage agree
  always_ff @(posedge core_clk_i)
  begin
    pin_s1_reg <= port_pin_i;
    pin_s2_reg <= pin_s1_reg;
    pin_s3_reg <= pin_s2_reg;
    if (!rst_n_i)
      pin_lvl_reg <= '0;
    else
      pin_lvl_reg <= (pin_s2_reg & pin_s3_reg) | (pin_lvl_reg & (pin_s2_reg ^ pin_s3_reg));
  end

  // configuration and mode registers
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      chan_reg <= '0;
      conv_clk_sel_reg <= '0;
      acq_time_sel_reg <= ACQ_CODE_NONE;
      calib_request_reg <= 1'b0;
      analog_pin_cfg_a_reg <= '0;
      compare_mode_sel_reg <= '0;
    end
    else
    begin
      if (wr_ctrl)
        chan_reg <= wdata_reg[CTRL_CHAN_LSB +: CHAN_W];
      if (wr_cfg)
      begin
        conv_clk_sel_reg <= wdata_reg[CFG_CLK_LSB +: SEL_W];
        acq_time_sel_reg <= wdata_reg[CFG_ACQ_LSB +: SEL_W];
        calib_request_reg <= wdata_reg[CFG_CAL_BIT];
      end
      if (wr_fire && wstrb_reg[0] && waddr_reg == OFS_PIN_CFG)
        analog_pin_cfg_a_reg <= wdata_reg[PIN_W-1:0];
      if (wr_fire && wstrb_reg[0] && waddr_reg == OFS_CMP_MODE)
        compare_mode_sel_reg <= wdata_reg[MODE_W-1:0];
    end
  end

  // compare unit special event trigger
  assign trig_hit = trig_i && (compare_mode_sel_reg == MODE_SPECIAL_TRIG);

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      timer_clr_o <= 1'b0;
    else
      timer_clr_o <= trig_hit;
  end

  // sequencing status
  assign conv_busy = (state_reg == ST_DELAY) || (state_reg == ST_ACQ) || (state_reg == ST_CONV);
  assign conv_finish = (state_reg == ST_CONV) && tad_tick && start_reg &&
                       (tad_cnt_reg[3:0] == CONV_TADS - 4'h1);
  assign conv_abort = conv_busy && !start_reg;

  // enable and start; a start write only counts once the converter was already on
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      converter_on_reg <= 1'b0;
      start_reg <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      converter_on_reg <= wdata_reg[CTRL_ON_BIT];
      start_reg <= wdata_reg[CTRL_START_BIT] && wdata_reg[CTRL_ON_BIT] &&
                   converter_on_reg;
    end
    else if (trig_hit && converter_on_reg)
      start_reg <= 1'b1;
    else if (conv_finish)
      start_reg <= 1'b0;
  end

  // done flag: hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      conv_done_flag_reg <= 1'b0;
    else if (conv_finish)
      conv_done_flag_reg <= 1'b1;
    else if (wr_fire && wstrb_reg[0] && waddr_reg == OFS_STATUS &&
             wdata_reg[STAT_DONE_BIT])
      conv_done_flag_reg <= 1'b0;
  end

  // acquisition length per code, in bit periods
  always_comb
  begin
    unique case (acq_time_sel_reg)
      3'h1: acq_len = ACQ_TADS_CODE1;
      ACQ_CODE_FOUR: acq_len = ACQ_TADS_FOUR;
      3'h3: acq_len = ACQ_TADS_CODE3;
      3'h4: acq_len = ACQ_TADS_CODE4;
      3'h5: acq_len = ACQ_TADS_CODE5;
      3'h6: acq_len = ACQ_TADS_CODE6;
      3'h7: acq_len = ACQ_TADS_CODE7;
      default: acq_len = 5'h00;
    endcase
  end

  // successive approximation: first period opens the hold switch, then bits 9..0
  assign bit_idx = 4'(RES_W) - tad_cnt_reg[3:0];

  always_comb
  begin
    code_next = code_reg;
    code_next[bit_idx] = cmp_i;
    if (bit_idx != 4'h0)
      code_next[bit_idx - 4'h1] = 1'b1;
  end

  assign corrected = (code_next > offset_reg) ? code_next - offset_reg : '0;

  // main sequence; channel and pin direction never enter this flow
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= ST_SAMPLE;
      tad_cnt_reg <= 5'h00;
      dly_cnt_reg <= 3'h0;
      acq_len_reg <= 5'h00;
      tad_clr_reg <= 1'b0;
      code_reg <= '0;
      cal_run_reg <= 1'b0;
    end
    else
    begin
      tad_clr_reg <= 1'b0;
      if (!converter_on_reg)
      begin
        state_reg <= ST_SAMPLE;
        cal_run_reg <= 1'b0;
      end
      else
      begin
        unique case (state_reg)
          ST_SAMPLE:
            if (start_reg)
            begin
              cal_run_reg <= cal_pending_reg;
              tad_cnt_reg <= 5'h00;
              tad_clr_reg <= 1'b1;
              acq_len_reg <= acq_len;
              dly_cnt_reg <= 3'h1;
              // start stays set during acquisition and conversion alike
              state_reg <= (acq_len == 5'h00) ? ST_DELAY : ST_ACQ;
            end
          ST_DELAY:
            if (conv_abort)
            begin
              tad_cnt_reg <= 5'h00;
              state_reg <= ST_HOLD;
            end
            else if (dly_cnt_reg == INSTR_CYCLES)
            begin
              tad_clr_reg <= 1'b1;
              code_reg <= '0;
              state_reg <= ST_CONV;
            end
            else
              dly_cnt_reg <= dly_cnt_reg + 3'h1;
          ST_ACQ:
            if (conv_abort)
            begin
              tad_cnt_reg <= 5'h00;
              state_reg <= ST_HOLD;
            end
            else if (tad_tick && tad_cnt_reg == acq_len_reg - 5'h01)
            begin
              tad_cnt_reg <= 5'h00;
              code_reg <= '0;
              state_reg <= ST_CONV;
            end
            else if (tad_tick)
              tad_cnt_reg <= tad_cnt_reg + 5'h01;
          ST_CONV:
            if (conv_abort || conv_finish)
            begin
              tad_cnt_reg <= 5'h00;
              state_reg <= ST_HOLD;
            end
            else if (tad_tick)
            begin
              if (tad_cnt_reg != 5'h00)
                code_reg <= code_next;
              else
                code_reg <= {1'b1, {(RES_W-1){1'b0}}};
              tad_cnt_reg <= tad_cnt_reg + 5'h01;
            end
          ST_HOLD:
            if (tad_tick && tad_cnt_reg[3:0] == HOLD_TADS - 4'h1)
            begin
              // dummy run over, so the channel is tracked again
              cal_run_reg <= 1'b0;
              state_reg <= ST_SAMPLE;
            end
            else if (tad_tick)
              tad_cnt_reg <= tad_cnt_reg + 5'h01;
          default:
            state_reg <= ST_SAMPLE;
        endcase
      end
    end
  end

  // calibration arming and offset store
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      cal_pending_reg <= 1'b0;
      offset_reg <= '0;
    end
    else if (conv_finish && cal_run_reg)
    begin
      cal_pending_reg <= 1'b0;
      offset_reg <= code_next;
    end
    else if (wr_cfg && wdata_reg[CFG_CAL_BIT] && !calib_request_reg)
      cal_pending_reg <= 1'b1;
  end

  // result pair: no reset so a power-up leaves whatever it holds
  always_ff @(posedge core_clk_i)
  begin
    if (conv_finish && !cal_run_reg)
      result_reg <= corrected;
    else if (wr_fire && wstrb_reg[0] && waddr_reg == OFS_RES_HIGH)
      result_reg[RES_W-1:8] <= wdata_reg[RES_W-9:0];
    else if (wr_fire && wstrb_reg[0] && waddr_reg == OFS_RES_LOW)
      result_reg[7:0] <= wdata_reg[7:0];
  end

  // front end drive
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      sample_o <= 1'b0;
      channel_sel_o <= '0;
      trial_code_o <= '0;
      cal_mode_o <= 1'b0;
    end
    else
    begin
      sample_o <= converter_on_reg && !cal_run_reg &&
                  (state_reg == ST_SAMPLE || state_reg == ST_ACQ);
      channel_sel_o <= chan_reg;
      trial_code_o <= code_reg;
      cal_mode_o <= cal_run_reg && conv_busy;
    end
  end

  assign s_axi_awready_o = aw_rdy_reg;
  assign s_axi_wready_o = w_rdy_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = RESP_OKAY;
  assign s_axi_arready_o = ar_rdy_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
endmodule : acqs_sequencer

//--- hw/acqs_tad_gen.sv
// Purpose: conversion-bit period tick generator
// Assumes: rc_clk_i is asynchronous to core_clk_i
// Notes: tick_o is a one-cycle pulse at the end of each period
`timescale 1ns/1ps
module acqs_tad_gen
  import acqs_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic clr_i,
  input wire logic [acqs_pkg::SEL_W-1:0] sel_i,
  input wire logic rc_clk_i,
  // period tick
  output logic tick_o
);
  import acqs_pkg::*;

  logic [6:0] div_cnt_reg;
  logic [6:0] div_val;
  logic rc_s1_reg;
  logic rc_s2_reg;
  logic rc_s3_reg;
  logic rc_lvl_reg;
  logic use_rc;
  logic rc_rise;

  // codes 011 and the unused 111 both pick the rc oscillator
  assign use_rc = (sel_i[1:0] == CLKSEL_RC[1:0]);
  assign rc_rise = (rc_s2_reg == rc_s3_reg) && rc_s3_reg && !rc_lvl_reg;

  always_comb
  begin
    unique case (sel_i)
      CLKSEL_DIV2: div_val = DIV_2;
      CLKSEL_DIV4: div_val = DIV_4;
      CLKSEL_DIV8: div_val = DIV_8;
      CLKSEL_DIV16: div_val = DIV_16;
      CLKSEL_DIV32: div_val = DIV_32;
      CLKSEL_DIV64: div_val = DIV_64;
      default: div_val = DIV_2;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    rc_s1_reg <= rc_clk_i;
    rc_s2_reg <= rc_s1_reg;
    rc_s3_reg <= rc_s2_reg;
    if (!rst_n_i)
      rc_lvl_reg <= 1'b0;
    else if (rc_s2_reg == rc_s3_reg)
      rc_lvl_reg <= rc_s3_reg;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || clr_i)
    begin
      div_cnt_reg <= 7'h00;
      tick_o <= 1'b0;
    end
    else if (use_rc)
    begin
      div_cnt_reg <= 7'h00;
      tick_o <= rc_rise;
    end
    else if (div_cnt_reg == div_val - 7'h01)
    begin
      div_cnt_reg <= 7'h00;
      tick_o <= 1'b1;
    end
    else
    begin
      div_cnt_reg <= div_cnt_reg + 7'h01;
      tick_o <= 1'b0;
    end
  end
endmodule : acqs_tad_gen

//--- tb/acqs_afe_model.sv
// Purpose: comparator model of the sample-and-hold and channel mux
// Assumes: fixed level per channel, fixed offset seen in calibration
// Notes: output wanders while tracking, nothing may rely on it
`timescale 1ns/1ps
module acqs_afe_model
#(
  parameter logic [9:0] CAL_LVL = 10'h005
)
(
  // clock
  input wire logic core_clk_i,
  // from the sequencer
  input wire logic sample_i,
  input wire logic cal_i,
  input wire logic [3:0] chan_i,
  input wire logic [9:0] trial_i,
  // comparator
  output logic cmp_o
);
  logic tog = 1'b0;
  logic [9:0] lvl;
  always @(posedge core_clk_i) tog <= ~tog;
  // dummy conversion reads no channel
  assign lvl = cal_i ? CAL_LVL : 10'(chan_i * 61 + 7);
  assign cmp_o = (sample_i && !cal_i) ? tog : (lvl >= trial_i);
endmodule : acqs_afe_model

//--- tb/acqs_seq_assertions.sv
// Purpose: port checks for the conversion sequencer
// Assumes: one core clock domain, synchronous reset
// Notes: bound to every sequencer instance
`timescale 1ns/1ps
module acqs_seq_chk
  import acqs_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // register bus
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [acqs_pkg::DATA_W-1:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // front end and trigger
  input wire logic sample_o,
  input wire logic cal_mode_o,
  input wire logic trig_i,
  input wire logic timer_clr_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  write_answer_a: assert property (wr_take |=> !s_axi_awready_o ##1 s_axi_bvalid_o)
    else $error("write answer not two cycles after acceptance");
  resp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response dropped early");
  resp_okay_a: assert property (s_axi_bvalid_o |-> s_axi_bresp_o == RESP_OKAY)
    else $error("write response not okay");
  write_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("new write accepted during response");
  read_answer_a: assert property (rd_take |=> s_axi_rvalid_o)
    else $error("read data late");
  read_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data changed before taken");
  read_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read accepted during data phase");
  timer_clear_a: assert property (timer_clr_o |-> $past(trig_i) ##1 !timer_clr_o)
    else $error("timer clear without trigger");
  cal_isolate_a: assert property (cal_mode_o |-> !sample_o)
    else $error("channel sampled during dummy conversion");
endmodule : acqs_seq_chk
bind acqs_sequencer acqs_seq_chk u_acqs_seq_chk (.core_clk_i, .rst_n_i, .s_axi_awvalid_i,
  .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
  .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
  .s_axi_rready_i, .sample_o, .cal_mode_o, .trig_i, .timer_clr_o);

//--- tb/acqs_sequencer_tb_top.sv
// Purpose: self-checking bench for the conversion sequencer
// Assumes: rc oscillator runs free at eight core clocks
// Notes: expected codes come from the bench level table
`timescale 1ns/1ps
module acqs_sequencer_tb_top;
  import acqs_pkg::*;
  logic clk = 0, rst_n = 0, rc = 0, trig = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [4:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d, d2;
  logic [7:0] pins = 0;
  wire logic awready, wready, bvalid, arready, rvalid, samp, cal, tclr, cmp;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0] chan;
  wire logic [9:0] trial;
  int err_total = 0, checked = 0, cyc = 0, t_b = 0, t_fall = 0, t_rise = 0, off = 0, i;
  int lo, tl;
  logic prev_s = 0, prev_b = 0, cal_seen = 0, tclr_seen = 0;
  logic [9:0] exp_res;
  logic [3:0] ch;
  int nd[6] = '{2, 4, 8, 16, 32, 64};
  logic [2:0] cs[6] = '{CLKSEL_DIV2, CLKSEL_DIV4, CLKSEL_DIV8, CLKSEL_DIV16, CLKSEL_DIV32,
    CLKSEL_DIV64};
  int al[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  acqs_sequencer u_acqs_sequencer (.core_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .cmp_i(cmp), .rc_clk_i(rc), .sample_o(samp),
    .channel_sel_o(chan), .trial_code_o(trial), .cal_mode_o(cal), .port_pin_i(pins),
    .trig_i(trig), .timer_clr_o(tclr));
  acqs_afe_model u_acqs_afe_model (.core_clk_i(clk), .sample_i(samp), .cal_i(cal),
    .chan_i(chan), .trial_i(trial), .cmp_o(cmp));
  initial forever #20 clk = ~clk;
  // rc phase kept unrelated to the core clock
  initial begin
    #13;
    forever #160 rc = ~rc;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prev_s <= samp;
    prev_b <= bvalid;
    if (prev_s && !samp) t_fall <= cyc;
    if (!prev_s && samp) t_rise <= cyc;
    if (!prev_b && bvalid) t_b <= cyc;
    if (cal) cal_seen <= 1;
    if (tclr) tclr_seen <= 1;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      bready <= bvalid;
    end while (!(bvalid && bready));
    bready <= 0;
  endtask : wr
  task rd(input logic [4:0] a, output logic [31:0] v);
    @(posedge clk);
    araddr <= a; arvalid <= 1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 0;
      rready <= rvalid;
    end while (!(rvalid && rready));
    v = rdata;
    rready <= 0;
  endtask : rd
  task wait_rise;
    i = 0;
    while (t_rise <= t_b && i < 20000) begin
      @(posedge clk);
      i++;
    end
    if (i >= 20000) err_total++;
    @(posedge clk);
  endtask : wait_rise
  task run(input logic [2:0] c, input logic [2:0] aq, input int n, input logic cl,
    input logic tg);
    ch = 4'($urandom % 16);
    wr(OFS_CONFIG, {25'h0, cl, aq, c});
    wr(OFS_CONTROL, {26'h0, ch, 2'b01});
    if (tg) begin
      @(posedge clk) trig <= 1;
      @(posedge clk) trig <= 0;
      t_b = cyc;
    end else wr(OFS_CONTROL, {26'h0, ch, 2'b11});
    rd(OFS_CONTROL, d);
    chk("busy", d[1], 1);
    wait_rise();
    // a dummy run keeps the channel untracked through its acquisition as well
    lo = 13 * n + (aq == 0 ? 4 : (cl ? al[aq] * n + 2 : 0));
    tl = (c == CLKSEL_RC) ? 8 : (aq == 0 ? n : 2);
    chk("lowspan", (t_rise - t_fall >= lo - 2) && (t_rise - t_fall <= lo + tl), 1);
    // the first rc period after a clear may come short
    i = t_fall - t_b - (cl ? 0 : al[aq] * n) + ((c == CLKSEL_RC) ? 4 : 0);
    tl = (c == CLKSEL_RC) ? 8 : 4;
    if (!tg) chk("acqspan", i inside {[0:tl]}, 1);
    if (!cl) exp_res = (ch * 61 + 7 > off) ? 10'(ch * 61 + 7 - off) : 10'h000;
    rd(OFS_RES_HIGH, d2);
    rd(OFS_RES_LOW, d);
    chk("result", {22'h0, d2[1:0], d[7:0]}, {22'h0, exp_res});
    rd(OFS_STATUS, d);
    chk("doneflag", d, 1);
    rd(OFS_CONTROL, d);
    chk("ctrl", d, {26'h0, ch, 2'b01});
    chk("chan", chan, ch);
    wr(OFS_STATUS, 1);
    rd(OFS_STATUS, d);
    chk("doneclr", d, 0);
  endtask : run
  task stop_test;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    stop_test();
  end
  initial begin
    void'($urandom(27));
    repeat (16) @(posedge clk);
    rst_n <= 1;
    foreach (cs[k]) begin
      rd(5'(k * 4 + (k > 1 ? 8 : 0)), d);
      chk("resetval", d, 0);
    end
    pins <= 8'($urandom);
    wr(OFS_PIN_CFG, 32'h0000000F);
    repeat (4) @(posedge clk);
    rd(OFS_PORT, d);
    chk("port", d, {24'h0, pins & 8'h0F});
    wr(OFS_CONTROL, 32'h0000000F);
    rd(OFS_CONTROL, d);
    chk("startdrop", d, 32'h0000000D);
    foreach (cs[k]) run(cs[k], 3'(k + 1), nd[k], 0, 0);
    run(CLKSEL_DIV8, ACQ_CODE_NONE, 8, 0, 0);
    run(CLKSEL_RC, 3'h7, 8, 0, 0);
    wr(OFS_CONFIG, {26'h0, ACQ_CODE_NONE, CLKSEL_DIV64});
    wr(OFS_CONTROL, 32'h00000017);
    repeat (200) @(posedge clk);
    wr(OFS_CONTROL, 32'h00000015);
    wait_rise();
    chk("abortgap", (t_rise - t_b) inside {[64:132]}, 1);
    rd(OFS_RES_LOW, d);
    chk("abortres", d, {24'h0, exp_res[7:0]});
    rd(OFS_STATUS, d);
    chk("abortflag", d, 0);
    wr(OFS_CMP_MODE, {28'h0, MODE_SPECIAL_TRIG});
    wr(OFS_CONTROL, 0);
    tclr_seen = 0;
    @(posedge clk) trig <= 1;
    @(posedge clk) trig <= 0;
    repeat (3) @(posedge clk);
    chk("tclroff", tclr_seen, 1);
    rd(OFS_CONTROL, d);
    chk("trigoff", d, 0);
    tclr_seen = 0;
    run(CLKSEL_DIV4, ACQ_CODE_FOUR, 4, 0, 1);
    chk("tclron", tclr_seen, 1);
    cal_seen = 0;
    run(CLKSEL_DIV2, ACQ_CODE_FOUR, 2, 1, 0);
    chk("calrun", cal_seen, 1);
    off = 5;
    run(CLKSEL_DIV4, ACQ_CODE_FOUR, 4, 0, 0);
    stop_test();
  end
endmodule : acqs_sequencer_tb_top
